// *** verilog/frp_pkg.sv ***
// Purpose: shared constants and types for flash read-out/write protection
// Assumes: single clock, asynchronous active-high reset
// Notes:   password storage is modelled as a small word that reset clears to FRP_PW_RESET
package frp_pkg;

  localparam int unsigned FRP_PW_W     = 8;
  localparam int unsigned FRP_PW_MSB   = FRP_PW_W - 1;
  localparam int unsigned FRP_ADDR_W   = 16;
  localparam int unsigned FRP_DATA_W   = 8;
  localparam int unsigned FRP_BOOT_MODE_W  = 4;
  localparam logic [3:0]  FRP_BOOT_MODE_PW = 4'h6;
  localparam logic [7:0]  FRP_PW_RESET  = 8'h00;
  localparam int unsigned FRP_ERASE_CYC = 4;
  localparam logic [1:0]  FRP_OP_READ  = 2'h0;
  localparam logic [1:0]  FRP_OP_PROG  = 2'h1;
  localparam logic [1:0]  FRP_OP_ERASE = 2'h2;

  // code / target regions
  typedef enum logic [1:0] {
    FRP_REG_BOOT = 2'b00,
    FRP_REG_PFL  = 2'b01,
    FRP_REG_DFL  = 2'b10,
    FRP_REG_RAM  = 2'b11
  } frp_region_t;

  typedef enum logic [1:0] {
    FRP_ST_IDLE  = 2'b00,
    FRP_ST_ERASE = 2'b01,
    FRP_ST_DONE  = 2'b10
  } frp_state_t;

endpackage

// *** verilog/frp_pw_if.sv ***
`timescale 1ns/1ns
// Purpose: link between protection logic and password store
// Assumes: one write port, registered read
// Notes:   none
interface frp_pw_if;
  logic       wr;
  logic       clr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       valid;
  modport ctrl  (output wr, output clr, output wdata, input rdata, input valid);
  modport store (input wr, input clr, input wdata, output rdata, output valid);
endinterface

// *** verilog/frp_pw_store.sv ***
`timescale 1ns/1ns
// Purpose: password word and its valid flag, read data registered
// Assumes: clear has priority only when no write in same cycle
// Notes:   none
module frp_pw_store (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // password port
  frp_pw_if.store  pw
);
  import frp_pkg::*;

  logic [7:0] word_reg, word_next;
  logic       val_reg, val_next;

  always_comb begin
    word_next = word_reg;
    val_next  = val_reg;
    if (pw.wr) begin
      word_next = pw.wdata;
      val_next  = 1'b1;
    end else if (pw.clr) begin
      word_next = FRP_PW_RESET;
      val_next  = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_reg <= FRP_PW_RESET;
      val_reg  <= 1'b0;
    end else begin
      word_reg <= word_next;
      val_reg  <= val_next;
    end
  end

  assign pw.rdata = word_reg;
  assign pw.valid = val_reg;
endmodule

// *** verilog/frp_protect.sv ***
`timescale 1ns/1ns
// Purpose: gate core read/program/erase requests to the two flash banks
// Assumes: requests are one-cycle pulses synchronous to clk
// Notes:   unlock takes effect at the following reset

module frp_protect (
  // clock and reset
  input  wire logic                             clk,
  input  wire logic                             rst,
  // core access request
  input  wire logic                             req_valid,
  input  wire logic [1:0]                       req_op,
  input  wire frp_pkg::frp_region_t             req_target,
  input  wire frp_pkg::frp_region_t             req_code,
  input  wire logic                             req_external,
  // boot loader password port
  input  wire logic                             boot_loader_valid,
  input  wire logic [frp_pkg::FRP_BOOT_MODE_W-1:0] boot_loader_mode,
  input  wire logic [frp_pkg::FRP_PW_W-1:0]     boot_loader_pw,
  // miscellaneous_control enable bit set pulse
  input  wire logic                             data_bank_erase_enable_set,
  // flash bank side
  output logic                                  flash_valid,
  output logic [1:0]                            flash_op,
  output frp_pkg::frp_region_t                  flash_bank,
  output logic                                  flash_erase_pfl,
  output logic                                  flash_erase_dfl,
  // status
  output logic                                  req_denied,
  output logic                                  protect_active,
  output logic                                  protect_mode,
  output logic                                  pw_match,
  output logic                                  data_bank_erase_enable
);
  import frp_pkg::*;

  frp_pw_if pw ();

  frp_pw_store u_store (
    .clk (clk),
    .rst (rst),
    .pw  (pw)
  );

  // ************************************
  // access decision
  // ************************************
  function automatic logic allow_fn(input logic act, input logic mode, input logic [1:0] op,
                                     input frp_region_t tgt, input frp_region_t code,
                                     input logic ext, input logic den);
    logic ok;
    logic from_flash;
    ok = 1'b1;
    from_flash = (code == FRP_REG_PFL) || (code == FRP_REG_DFL);
    if (tgt == FRP_REG_BOOT && ext)
      ok = 1'b0;
    else if (act) begin
      if (op == FRP_OP_READ) begin
        if (!mode)
          ok = (tgt == FRP_REG_PFL) ? (code == FRP_REG_PFL) : 1'b1;
        else if (tgt == FRP_REG_PFL || tgt == FRP_REG_DFL)
          ok = from_flash;
      end else begin
        if (tgt == FRP_REG_PFL)
          ok = 1'b0;
        else if (tgt == FRP_REG_DFL && mode)
          ok = 1'b0;
        else if (tgt == FRP_REG_DFL && op == FRP_OP_ERASE)
          ok = den;
      end
    end
    return ok;
  endfunction

  // ************************************
  // state
  // ************************************
  frp_state_t st_reg, st_next;
  logic       act_reg, act_next;
  logic       unl_reg, unl_next;
  logic       den_reg, den_next;
  logic [2:0] cnt_reg, cnt_next;
  logic       mode_reg, mode_next;
  logic       allow;
  logic       grant;
  logic       pw_cmd;
  logic       mode;

  // mode held apart from the store, so an unlock cannot weaken it before reset
  assign mode   = mode_reg;
  assign pw_cmd = boot_loader_valid && (boot_loader_mode == FRP_BOOT_MODE_PW);
  assign allow  = allow_fn(act_reg, mode, req_op, req_target, req_code, req_external,
                           den_reg);
  assign grant  = req_valid && allow && (st_reg != FRP_ST_ERASE);

  always_comb begin
    st_next  = st_reg;
    act_next = act_reg;
    unl_next = unl_reg;
    den_next = den_reg;
    cnt_next = cnt_reg;
    mode_next = mode_reg;
    pw.wr    = 1'b0;
    pw.clr   = 1'b0;
    pw.wdata = boot_loader_pw;
    if (grant && req_target == FRP_REG_DFL && req_op == FRP_OP_ERASE)
      den_next = 1'b0;
    // set wins over a same-cycle erase
    if (data_bank_erase_enable_set)
      den_next = 1'b1;
    case (st_reg)
      FRP_ST_IDLE: begin
        if (pw_cmd && !unl_reg) begin
          if (!pw.valid) begin
            pw.wr    = 1'b1;
            act_next = 1'b1;
            mode_next = boot_loader_pw[FRP_PW_MSB];
          end else if (boot_loader_pw == pw.rdata) begin
            st_next  = FRP_ST_ERASE;
            cnt_next = 3'(FRP_ERASE_CYC - 1);
          end
        end
      end
      FRP_ST_ERASE: begin
        if (cnt_reg == 3'h0) begin
          pw.clr   = 1'b1;
          unl_next = 1'b1;
          st_next  = FRP_ST_DONE;
        end else begin
          cnt_next = cnt_reg - 3'h1;
        end
      end
      FRP_ST_DONE: begin
        st_next = FRP_ST_DONE;
      end
      default: st_next = FRP_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg  <= FRP_ST_IDLE;
      unl_reg <= 1'b0;
      den_reg <= 1'b0;
      cnt_reg <= 3'h0;
      mode_reg <= 1'b0;
    end else begin
      st_reg  <= st_next;
      unl_reg <= unl_next;
      den_reg <= den_next;
      cnt_reg <= cnt_next;
      mode_reg <= mode_next;
    end
  end

  // protection state follows stored password after reset
  logic rst_seen_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      act_reg      <= 1'b0;
      rst_seen_reg <= 1'b0;
    end else begin
      rst_seen_reg <= 1'b1;
      if (!rst_seen_reg)
        act_reg <= pw.valid || act_next;
      else
        act_reg <= act_next;
    end
  end

  // ************************************
  // flash side outputs
  // ************************************
  logic       fv_reg, ep_reg, ed_reg, dn_reg;
  logic [1:0] fo_reg;
  frp_region_t fb_reg;
  logic       erase_go;

  assign erase_go = (st_reg == FRP_ST_ERASE) && (cnt_reg == 3'(FRP_ERASE_CYC - 1));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fv_reg <= 1'b0;
      fo_reg <= FRP_OP_READ;
      fb_reg <= FRP_REG_BOOT;
      ep_reg <= 1'b0;
      ed_reg <= 1'b0;
      dn_reg <= 1'b0;
    end else begin
      fv_reg <= grant;
      fo_reg <= req_op;
      fb_reg <= req_target;
      dn_reg <= req_valid && !allow;
      ep_reg <= erase_go;
      ed_reg <= erase_go && mode;
    end
  end

  assign flash_valid            = fv_reg;
  assign flash_op               = fo_reg;
  assign flash_bank             = fb_reg;
  assign flash_erase_pfl        = ep_reg;
  assign flash_erase_dfl        = ed_reg;
  assign req_denied             = dn_reg;
  assign protect_active         = act_reg;
  assign protect_mode           = mode;
  assign pw_match               = (st_reg == FRP_ST_ERASE);
  assign data_bank_erase_enable = den_reg;

  // ************************************
  // checks
  // ************************************
  a_boot_never_out: assert property (@(posedge clk) disable iff (rst)
    req_valid && req_external && req_target == FRP_REG_BOOT |=> !flash_valid && req_denied)
    else $error("external boot read passed");
  a_pfl_no_write: assert property (@(posedge clk) disable iff (rst)
    req_valid && act_reg && req_op != FRP_OP_READ && req_target == FRP_REG_PFL
    |=> !flash_valid)
    else $error("program bank write passed");
  a_mode1_dfl_ro: assert property (@(posedge clk) disable iff (rst)
    req_valid && act_reg && mode && req_op != FRP_OP_READ && req_target == FRP_REG_DFL
    |=> req_denied)
    else $error("data bank write in mode 1");
  a_mode0_pfl_rd: assert property (@(posedge clk) disable iff (rst)
    req_valid && act_reg && !mode && req_op == FRP_OP_READ && req_target == FRP_REG_PFL
    && req_code != FRP_REG_PFL |=> req_denied)
    else $error("program read from outside");
  a_mode0_dfl_rd: assert property (@(posedge clk) disable iff (rst)
    req_valid && !req_external && !mode && req_op == FRP_OP_READ
    && req_target == FRP_REG_DFL |=> !req_denied)
    else $error("data read refused in mode 0");
  a_den_needed: assert property (@(posedge clk) disable iff (rst)
    req_valid && act_reg && !mode && req_op == FRP_OP_ERASE && req_target == FRP_REG_DFL
    && !den_reg |=> req_denied)
    else $error("erase without enable");
  a_match_erase: assert property (@(posedge clk) disable iff (rst)
    $rose(pw_match) |=> flash_erase_pfl ##[1:6] !pw.valid)
    else $error("match did not erase");
  a_erase_banks: assert property (@(posedge clk) disable iff (rst)
    flash_erase_dfl |-> flash_erase_pfl && mode)
    else $error("wrong erase banks");
  a_lock_holds: assert property (@(posedge clk) disable iff (rst)
    act_reg && st_reg != FRP_ST_IDLE |=> act_reg)
    else $error("protection dropped before reset");
  a_active_by_pw: assert property (@(posedge clk) disable iff (rst)
    $rose(act_reg) |-> $past(pw_cmd))
    else $error("protection on without password write");
  a_mode_from_pw: assert property (@(posedge clk) disable iff (rst)
    pw.wr |=> protect_mode == $past(boot_loader_pw[FRP_PW_MSB]))
    else $error("mode not taken from password top bit");
  a_mode0_dfl_prog: assert property (@(posedge clk) disable iff (rst)
    req_valid && act_reg && !mode && req_op == FRP_OP_PROG && req_target == FRP_REG_DFL
    && st_reg == FRP_ST_IDLE |=> flash_valid)
    else $error("data bank program refused in mode 0");
  a_mode1_reads: assert property (@(posedge clk) disable iff (rst)
    req_valid && act_reg && mode && req_op == FRP_OP_READ
    && (req_target == FRP_REG_PFL || req_target == FRP_REG_DFL)
    && req_code != FRP_REG_PFL && req_code != FRP_REG_DFL |=> req_denied)
    else $error("bank read from outside flash in mode 1");
  a_match_starts: assert property (@(posedge clk) disable iff (rst)
    st_reg == FRP_ST_IDLE && pw_cmd && pw.valid && !unl_reg
    && boot_loader_pw == pw.rdata |=> pw_match)
    else $error("matching password did not unlock");
  a_mismatch_idle: assert property (@(posedge clk) disable iff (rst)
    st_reg == FRP_ST_IDLE && pw_cmd && pw.valid
    && boot_loader_pw != pw.rdata |=> !pw_match)
    else $error("wrong password started unlock");
  a_erase_dfl_m1: assert property (@(posedge clk) disable iff (rst)
    $rose(pw_match) && mode |=> flash_erase_dfl)
    else $error("mode 1 unlock kept data bank");
  a_denied_dropped: assert property (@(posedge clk) disable iff (rst)
    req_valid && !allow |=> !flash_valid)
    else $error("refused request reached flash");
endmodule

// *** verification/frp_core_model.sv ***
`timescale 1ns/1ns
// Purpose: core and boot-loader side driving the protection gate
// Assumes: drives just after the falling edge, one-cycle pulses
// Notes:   released fields show inverted values, not the last ones
module frp_core_model (
  // clock
  input  wire logic                 clk,
  // core request
  output logic                      rq_v,
  output logic [1:0]                rq_op,
  output frp_pkg::frp_region_t      rq_tgt,
  output frp_pkg::frp_region_t      rq_code,
  output logic                      rq_ext,
  // boot loader and enable bit
  output logic                      bl_v,
  output logic [3:0]                bl_mode,
  output logic [7:0]                bl_pw,
  output logic                      en_set
);
  import frp_pkg::*;
  initial begin
    {rq_v, rq_op, rq_ext, bl_v, bl_mode, bl_pw, en_set} = '0;
    rq_tgt = FRP_REG_RAM;
    rq_code = FRP_REG_RAM;
  end
  // one core access
  task automatic issue(input logic [1:0] op, input frp_region_t t, input frp_region_t c,
                       input logic x);
    @(negedge clk);
    rq_v = 1'b1;
    rq_op = op;
    rq_tgt = t;
    rq_code = c;
    rq_ext = x;
    @(negedge clk);
    rq_v = 1'b0;
    rq_op = ~op;
    rq_tgt = frp_region_t'(~t);
    rq_code = frp_region_t'(~c);
    rq_ext = ~x;
  endtask
  // password write or unlock through the boot loader
  task automatic bl(input logic [3:0] m, input logic [7:0] pw);
    @(negedge clk);
    {bl_v, bl_mode, bl_pw} = {1'b1, m, pw};
    @(negedge clk);
    {bl_v, bl_mode, bl_pw} = {1'b0, ~m, ~pw};
  endtask
  // erase enable, one-cycle set pulse
  task automatic en_pulse();
    @(negedge clk);
    en_set = 1'b1;
    @(negedge clk);
    en_set = 1'b0;
  endtask
endmodule

// *** verification/frp_protect_tb_top.sv ***
`timescale 1ns/1ns
// Purpose: self-checking bench for the flash protection gate
// Assumes: stimulus on the falling edge, reset held 20 cycles
// Notes:   none
module frp_protect_tb_top;
  import frp_pkg::*;
  localparam logic [1:0]  RD = FRP_OP_READ;
  localparam logic [1:0]  PG = FRP_OP_PROG;
  localparam logic [1:0]  ER = FRP_OP_ERASE;
  localparam frp_region_t BT = FRP_REG_BOOT;
  localparam frp_region_t PF = FRP_REG_PFL;
  localparam frp_region_t DF = FRP_REG_DFL;
  localparam frp_region_t RM = FRP_REG_RAM;
  logic        clk, rst, rv, rx, bv, es, fv, fep, fed, den, pa, pm, pwm, dee;
  logic [1:0]  rop, fop;
  logic [3:0]  bm;
  logic [7:0]  bp;
  frp_region_t rt, rc, fb;
  int          n_errors, cmp_count;
  frp_core_model core_u (.clk(clk), .rq_v(rv), .rq_op(rop), .rq_tgt(rt), .rq_code(rc),
    .rq_ext(rx), .bl_v(bv), .bl_mode(bm), .bl_pw(bp), .en_set(es));
  frp_protect dut_u (.clk(clk), .rst(rst), .req_valid(rv), .req_op(rop), .req_target(rt),
    .req_code(rc), .req_external(rx), .boot_loader_valid(bv), .boot_loader_mode(bm),
    .boot_loader_pw(bp), .data_bank_erase_enable_set(es), .flash_valid(fv), .flash_op(fop),
    .flash_bank(fb), .flash_erase_pfl(fep), .flash_erase_dfl(fed), .req_denied(den),
    .protect_active(pa), .protect_mode(pm), .pw_match(pwm), .data_bank_erase_enable(dee));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one access, granted or refused one cycle later
  task automatic acc(input logic [1:0] op, input frp_region_t t, input frp_region_t c,
                     input logic x, input logic ok);
    core_u.issue(op, t, c, x);
    chk({7'h00, fv}, {7'h00, ok});
    chk({7'h00, den}, {7'h00, !ok});
    if (ok) begin
      chk({6'h00, fop}, {6'h00, op});
      chk({6'h00, fb}, {6'h00, t});
    end
  endtask
  task automatic do_rst();
    rst = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
  endtask
  task automatic set_pw(input logic [7:0] pw);
    core_u.bl(4'h6, pw);
    repeat (2) @(negedge clk);
    chk({7'h00, pa}, 8'h01);
    chk({7'h00, pm}, {7'h00, pw[7]});
  endtask
  task automatic unlock(input logic [7:0] pw, input logic dfl);
    core_u.bl(FRP_BOOT_MODE_PW, pw);
    chk({7'h00, pwm}, 8'h01);
    chk({6'h00, fep, fed}, 8'h00);
    @(negedge clk);
    chk({7'h00, pwm}, 8'h01);
    chk({6'h00, fep, fed}, {6'h00, 1'b1, dfl});
    repeat (5) @(negedge clk);
    chk({7'h00, pwm}, 8'h00);
    chk({7'h00, pm}, {7'h00, dfl});
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_open();
    do_rst();
    acc(RD, PF, RM, 1'b0, 1'b1);
    acc(PG, PF, RM, 1'b0, 1'b1);
    acc(RD, BT, RM, 1'b1, 1'b0);
    acc(RD, BT, BT, 1'b0, 1'b1);
    core_u.bl(4'h5, 8'h12);
    repeat (2) @(negedge clk);
    chk({7'h00, pa}, 8'h00);
  endtask
  task automatic t_mode0();
    set_pw(8'h12);
    acc(RD, PF, RM, 1'b0, 1'b0);
    acc(RD, PF, PF, 1'b0, 1'b1);
    acc(RD, PF, DF, 1'b0, 1'b0);
    acc(RD, DF, RM, 1'b0, 1'b1);
    acc(RD, DF, BT, 1'b0, 1'b1);
    acc(PG, PF, PF, 1'b0, 1'b0);
    acc(ER, PF, PF, 1'b0, 1'b0);
    acc(PG, DF, PF, 1'b0, 1'b1);
    acc(ER, DF, PF, 1'b0, 1'b0);
    core_u.en_pulse();
    chk({7'h00, dee}, 8'h01);
    acc(ER, DF, PF, 1'b0, 1'b1);
    chk({7'h00, dee}, 8'h00);
    acc(ER, DF, PF, 1'b0, 1'b0);
    core_u.bl(4'h6, 8'h92);
    @(posedge clk);
    #1;
    chk({7'h00, pwm}, 8'h00);
    repeat (2) @(negedge clk);
    chk({7'h00, pm}, 8'h00);
    unlock(8'h12, 1'b0);
    acc(RD, PF, RM, 1'b0, 1'b0);
    do_rst();
    chk({7'h00, pa}, 8'h00);
    acc(RD, PF, RM, 1'b0, 1'b1);
  endtask
  task automatic t_mode1();
    set_pw(8'h85);
    acc(RD, PF, DF, 1'b0, 1'b1);
    acc(RD, DF, PF, 1'b0, 1'b1);
    acc(RD, PF, RM, 1'b0, 1'b0);
    acc(RD, DF, RM, 1'b0, 1'b0);
    acc(PG, DF, PF, 1'b0, 1'b0);
    core_u.en_pulse();
    acc(ER, DF, PF, 1'b0, 1'b0);
    acc(ER, PF, DF, 1'b0, 1'b0);
    unlock(8'h85, 1'b1);
    do_rst();
  endtask
  task automatic report_and_stop();
    $display("errors %0d, comparisons %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #40000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    n_errors = 0;
    cmp_count = 0;
    t_open();
    t_mode0();
    t_mode1();
    report_and_stop();
  end
endmodule
